/* hdl/hpld_pkg.sv */
// package: constants, register map and types of the headphone load-detect block
package hpld_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 50_000_000; // system clock rate
  localparam int unsigned TONE_HZ       = 24_000;     // test tone frequency
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ); // rounds down
  localparam int unsigned RES_MEAS_NS   = 40_000;     // resistance settle time
  localparam int unsigned CAP_MEAS_NS   = 40_000;     // capacitance settle time
  localparam int unsigned RES_MEAS_CYC  = (RES_MEAS_NS * 50 + 999) / 1000;
  localparam int unsigned CAP_MEAS_CYC  = (CAP_MEAS_NS * 50 + 999) / 1000;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [4:0] OFS_CTRL   = 5'h00; // path control bits
  localparam logic [4:0] OFS_RAMP   = 5'h04; // ramp rates and slow start
  localparam logic [4:0] OFS_VOL    = 5'h08; // volume targets
  localparam logic [4:0] OFS_STATUS = 5'h0C; // detection status, read only
  localparam logic [4:0] OFS_VOLNOW = 5'h10; // applied volumes, read only

  // ****************************************************************
  // field codes
  // ****************************************************************
  localparam logic [1:0] RES_15_OHM   = 2'h0; // resistance codes
  localparam logic [1:0] RES_30_OHM   = 2'h1;
  localparam logic [1:0] RES_3K_OHM   = 2'h2; // only code above 300 ohm
  localparam logic [2:0] SLOW_ALL_ON  = 3'h7; // ramping enabled
  localparam logic [2:0] RAIL_ADAPT   = 3'h7; // adapt-to-signal
  localparam logic [2:0] RAIL_FIX_HI  = 3'h1; // first fixed rail code
  localparam logic [2:0] RAIL_FIX_LO  = 3'h4; // last fixed rail code
  localparam logic [31:0] CTRL_RST    = 32'h0000_000F; // muted, powered down
  localparam logic [31:0] RAMP_RST    = 32'h0000_0000;
  localparam int unsigned NCH         = 3; // mixer, converter, headphone

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [17:0] unused;                       // reads zero
    logic        load_detect_enable;           // bit 13
    logic        output_load_compensation;     // bit 12
    logic        output_max_level_sel;         // bit 11
    logic [2:0]  adaptive_rail_select;         // bits 10:8
    logic [1:0]  headset_bias_control;         // bits 7:6
    logic        latch_to_supply;              // bit 5
    logic        playback_highpass_enable;     // bit 4
    logic        capture_converter_power_down; // bit 3
    logic        headphone_power_down;         // bit 2
    logic        chan_b_analog_silence;        // bit 1
    logic        chan_a_analog_silence;        // bit 0
  } hpld_ctrl_s;

  typedef struct packed {
    logic [20:0] unused;          // reads zero
    logic [2:0]  slow_start;      // bits 10:8
    logic [3:0]  digital_rate;    // bits 7:4
    logic [3:0]  analog_ramp_rate;// bits 3:0
  } hpld_ramp_s;

  typedef enum {ST_IDLE, ST_RES, ST_CAP, ST_DONE} hpld_state_e;
endpackage : hpld_pkg

/* hdl/hpld_ctrl.sv */
// top module: headphone path control, load detect sequencer and volume ramps
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - each channel silenced by its mute bit
// - converter power follows driver power-down bit
// - detect on channel A, result covers both
// - plug event with enable starts measurement
// - tone on channel A, chosen contact sensed
// - resistance status 00,01,10; 11 reserved
// - low resistance skips capacitance step
// - end sets done flag and capacitance
// - slow start 111 steps every setting
// - step wait 1 to 72 sample periods
// - no ramp applies volume next edge
// - fixed rail codes hold rails constant
module hpld_ctrl #(
  parameter int unsigned RES_CYC = hpld_pkg::RES_MEAS_CYC, // resistance wait
  parameter int unsigned CAP_CYC = hpld_pkg::CAP_MEAS_CYC  // capacitance wait
) (
  input  wire logic        clk_i,            // 50 MHz clock
  input  wire logic        sys_rst_i,        // sync reset, active high
  input  wire logic [4:0]  address,          // avalon byte address
  input  wire logic        read,             // avalon read
  input  wire logic        write,            // avalon write
  input  wire logic [31:0] writedata,        // avalon write data
  output logic      [31:0] readdata,         // avalon read data
  output logic             waitrequest,      // avalon stall
  input  wire logic        plug_event_i,     // headphone plug-in pulse
  input  wire logic        headset_type_i,   // 1 selects contact four
  input  wire logic [1:0]  res_meas_i,       // resistance comparator code
  input  wire logic        cap_high_i,       // capacitance comparator
  input  wire logic        fs_tick_i,        // one pulse per sample period
  input  wire logic [1:0]  signal_rail_i,    // rail asked for by signal
  output logic             chan_a_mute_o,    // channel A silenced
  output logic             chan_b_mute_o,    // channel B silenced
  output logic             hp_power_down_o,  // amplifier power-down
  output logic [1:0]       dac_power_down_o, // converter power-down A,B
  output logic             adc_power_down_o, // capture converter down
  output logic             highpass_en_o,    // playback high-pass
  output logic             latch_supply_o,   // latch to supply
  output logic [1:0]       bias_ctrl_o,      // headset bias control
  output logic             max_level_o,      // full-scale level select
  output logic             load_comp_o,      // amplifier compensation
  output logic [1:0]       rail_level_o,     // 0 highest .. 3 lowest
  output logic             test_tone_o,      // tone on channel A out
  output logic             sense_four_o,     // sense contact four
  output logic             sense_en_o,       // resistor bank active
  output logic [7:0]       mix_vol_o,        // applied mixer volume
  output logic [7:0]       dac_vol_o,        // applied converter volume
  output logic [7:0]       hp_vol_o          // applied headphone volume
);
  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (RES_CYC < 1 || CAP_CYC < 1 || RES_CYC > 65535 || CAP_CYC > 65535)
  begin : g_bad
    $error("measurement wait out of range");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // rate code to whole sample periods per step, 1 .. 72
  function automatic logic [6:0] rate_periods(input logic [3:0] code);
    case (code)
      4'h0:    rate_periods = 7'h01;
      4'h1:    rate_periods = 7'h02;
      4'h2:    rate_periods = 7'h04;
      4'h3:    rate_periods = 7'h06;
      4'h4:    rate_periods = 7'h08;
      4'h5:    rate_periods = 7'h0B;
      4'h6:    rate_periods = 7'h10;
      4'h7:    rate_periods = 7'h14;
      4'h8:    rate_periods = 7'h18;
      4'h9:    rate_periods = 7'h20;
      4'hA:    rate_periods = 7'h28;
      4'hB:    rate_periods = 7'h30;
      4'hC:    rate_periods = 7'h38;
      4'hD:    rate_periods = 7'h40;
      4'hE:    rate_periods = 7'h44;
      default: rate_periods = 7'h48;
    endcase
  endfunction : rate_periods

  // ****************************************************************
  // register bus
  // ****************************************************************
  hpld_pkg::hpld_ctrl_s ctrl, next_ctrl;       // control bits
  hpld_pkg::hpld_ramp_s ramp, next_ramp;       // ramp setup
  logic [23:0]          vol_tgt, next_vol_tgt; // volume targets
  logic                 ack, next_ack;         // one-cycle answer
  logic [31:0]          next_readdata;         // read mux
  logic [7:0]           vol_now [hpld_pkg::NCH]; // applied volumes
  logic [1:0]           res_stat;              // resistance status
  logic                 cap_stat;              // capacitance status
  logic                 done;                  // detection done
  hpld_pkg::hpld_state_e state;                // sequencer state
  logic                 wr_go;                 // write takes effect

  // one wait state: answer at the second edge of every request
  assign waitrequest = (read | write) & ~ack;
  assign wr_go       = write & ack;

  // next values of bus-side registers
  always_comb
  begin
    next_ctrl     = ctrl;
    next_ramp     = ramp;
    next_vol_tgt  = vol_tgt;
    next_ack      = (read | write) & ~ack;
    next_readdata = readdata;
    if (wr_go)
    begin
      case (address)
        hpld_pkg::OFS_CTRL: next_ctrl = {18'h0, writedata[13:0]};
        hpld_pkg::OFS_RAMP: next_ramp = {21'h0, writedata[10:0]};
        hpld_pkg::OFS_VOL:  next_vol_tgt = writedata[23:0];
        default: ;                  // unmapped or read-only: ignored
      endcase
    end
    if (read & ~ack)                // data stands at the answering edge
    begin
      case (address)
        hpld_pkg::OFS_CTRL:   next_readdata = ctrl;
        hpld_pkg::OFS_RAMP:   next_readdata = ramp;
        hpld_pkg::OFS_VOL:    next_readdata = {8'h0, vol_tgt};
        hpld_pkg::OFS_STATUS: next_readdata = {26'h0,
                                (state != hpld_pkg::ST_IDLE &&
                                 state != hpld_pkg::ST_DONE),
                                done, 1'b0, cap_stat, res_stat};
        hpld_pkg::OFS_VOLNOW: next_readdata = {8'h0, vol_now[2],
                                vol_now[1], vol_now[0]};
        default:              next_readdata = 32'h0; // unmapped reads zero
      endcase
    end
  end

  // bus-side registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl     <= hpld_pkg::CTRL_RST;
      ramp     <= hpld_pkg::RAMP_RST;
      vol_tgt  <= 24'h0;
      ack      <= 1'b0;
      readdata <= 32'h0;
    end
    else
    begin
      ctrl     <= next_ctrl;
      ramp     <= next_ramp;
      vol_tgt  <= next_vol_tgt;
      ack      <= next_ack;
      readdata <= next_readdata;
    end
  end

  // ****************************************************************
  // path control and rails
  // ****************************************************************
  logic [1:0] next_rail; // rail level for the amplifier

  // fixed codes pin the rail, adapt code follows the signal
  always_comb
  begin
    next_rail = rail_level_o;
    if (ctrl.adaptive_rail_select >= hpld_pkg::RAIL_FIX_HI &&
        ctrl.adaptive_rail_select <= hpld_pkg::RAIL_FIX_LO)
      next_rail = 2'(ctrl.adaptive_rail_select - hpld_pkg::RAIL_FIX_HI);
    else if (ctrl.adaptive_rail_select == hpld_pkg::RAIL_ADAPT)
      next_rail = signal_rail_i;
  end

  // registered path outputs; mutes are per channel
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      chan_a_mute_o    <= 1'b1;
      chan_b_mute_o    <= 1'b1;
      hp_power_down_o  <= 1'b1;
      dac_power_down_o <= 2'h3;
      adc_power_down_o <= 1'b1;
      rail_level_o     <= 2'h0;
    end
    else
    begin
      chan_a_mute_o    <= ctrl.chan_a_analog_silence;
      chan_b_mute_o    <= ctrl.chan_b_analog_silence;
      hp_power_down_o  <= ctrl.headphone_power_down;
      dac_power_down_o <= {2{ctrl.headphone_power_down}};
      adc_power_down_o <= ctrl.capture_converter_power_down;
      rail_level_o     <= next_rail;
    end
  end
  // plain register images; the host keeps its own ordering
  assign highpass_en_o  = ctrl.playback_highpass_enable;
  assign latch_supply_o = ctrl.latch_to_supply;
  assign bias_ctrl_o    = ctrl.headset_bias_control;
  assign max_level_o    = ctrl.output_max_level_sel;
  assign load_comp_o    = ctrl.output_load_compensation;

  // ****************************************************************
  // load detect sequencer
  // ****************************************************************
  hpld_pkg::hpld_state_e next_state; // sequencer next state
  logic [15:0] wait_cnt, next_wait;  // settle counter
  logic [10:0] tone_cnt, next_tone;  // tone half-period counter
  logic        next_tone_o;          // tone level
  logic [1:0]  next_res;             // resistance status
  logic        next_cap, next_done;  // capacitance and done
  logic        start;                // sequence start

  assign start = plug_event_i & ctrl.load_detect_enable &
                 (state == hpld_pkg::ST_IDLE ||
                  state == hpld_pkg::ST_DONE);

  // only channel A is measured; the code serves both channels
  always_comb
  begin
    next_state  = state;
    next_wait   = wait_cnt;
    next_tone   = tone_cnt;
    next_tone_o = test_tone_o;
    next_res    = res_stat;
    next_cap    = cap_stat;
    next_done   = done;
    case (state)
      hpld_pkg::ST_IDLE, hpld_pkg::ST_DONE:
      begin
        next_tone   = 11'h0;
        next_tone_o = 1'b0;
        if (start)
        begin
          next_done  = 1'b0;
          next_wait  = 16'(RES_CYC - 1);
          next_state = hpld_pkg::ST_RES;
        end
      end
      hpld_pkg::ST_RES, hpld_pkg::ST_CAP:
      begin
        // 24 kHz square tone out of channel A
        if (tone_cnt == 11'(hpld_pkg::TONE_HALF_CYC - 1))
        begin
          next_tone   = 11'h0;
          next_tone_o = ~test_tone_o;
        end
        else
          next_tone = tone_cnt + 11'h1;
        if (wait_cnt != 16'h0)
          next_wait = wait_cnt - 16'h1;
        else if (state == hpld_pkg::ST_RES)
        begin
          // reserved comparator code is folded into the highest load
          next_res = (res_meas_i == 2'h3) ? hpld_pkg::RES_3K_OHM
                                          : res_meas_i;
          if (next_res == hpld_pkg::RES_3K_OHM)
          begin
            next_wait  = 16'(CAP_CYC - 1);
            next_state = hpld_pkg::ST_CAP;
          end
          else
          begin
            next_cap   = 1'b0;
            next_done  = 1'b1;
            next_state = hpld_pkg::ST_DONE;
          end
        end
        else
        begin
          next_cap   = cap_high_i;
          next_done  = 1'b1;
          next_state = hpld_pkg::ST_DONE;
        end
      end
      default: next_state = hpld_pkg::ST_IDLE;
    endcase
  end

  // sequencer registers; done clears at start, resistance status moves at the end of its wait, capacitance at the end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state       <= hpld_pkg::ST_IDLE;
      wait_cnt    <= 16'h0;
      tone_cnt    <= 11'h0;
      test_tone_o <= 1'b0;
      res_stat    <= hpld_pkg::RES_15_OHM;
      cap_stat    <= 1'b0;
      done        <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      wait_cnt    <= next_wait;
      tone_cnt    <= next_tone;
      test_tone_o <= next_tone_o;
      res_stat    <= next_res;
      cap_stat    <= next_cap;
      done        <= next_done;
    end
  end
  assign sense_en_o   = (state == hpld_pkg::ST_RES ||
                         state == hpld_pkg::ST_CAP);
  assign sense_four_o = headset_type_i;

  // ****************************************************************
  // volume soft ramp
  // ****************************************************************
  logic       ramp_on;                      // slow start enabled
  logic [7:0] next_vol [hpld_pkg::NCH];     // next applied volumes
  logic [6:0] step_cnt [hpld_pkg::NCH];     // periods since last step
  logic [6:0] next_step [hpld_pkg::NCH];    // next period count

  assign ramp_on = (ramp.slow_start == hpld_pkg::SLOW_ALL_ON);

  // mixer and converter use the digital rate, headphone the analog one
  always_comb
  begin
    for (int c = 0; c < hpld_pkg::NCH; c++)
    begin
      logic [7:0] tgt;
      logic [6:0] per;
      tgt          = vol_tgt[c*8 +: 8];
      per          = rate_periods((c == 2) ? ramp.analog_ramp_rate
                                           : ramp.digital_rate);
      next_vol[c]  = vol_now[c];
      next_step[c] = step_cnt[c];
      if (!ramp_on)
      begin
        next_vol[c]  = tgt;
        next_step[c] = 7'h0;
      end
      else if (vol_now[c] == tgt)
        next_step[c] = 7'h0;
      else if (fs_tick_i)
      begin
        if (step_cnt[c] + 7'h1 >= per)
        begin
          next_step[c] = 7'h0;
          next_vol[c]  = (vol_now[c] < tgt) ? vol_now[c] + 8'h1
                                            : vol_now[c] - 8'h1;
        end
        else
          next_step[c] = step_cnt[c] + 7'h1;
      end
    end
  end

  // ramp registers
  always_ff @(posedge clk_i)
  begin
    for (int c = 0; c < hpld_pkg::NCH; c++)
    begin
      vol_now[c]  <= sys_rst_i ? 8'h0 : next_vol[c];
      step_cnt[c] <= sys_rst_i ? 7'h0 : next_step[c];
    end
  end
  assign mix_vol_o = vol_now[0];
  assign dac_vol_o = vol_now[1];
  assign hp_vol_o  = vol_now[2];

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_res_end;
    state == hpld_pkg::ST_RES && wait_cnt == 16'h0;
  endsequence
  property p_mute_a;
    @(posedge clk_i) disable iff (sys_rst_i)
    wr_go && address == hpld_pkg::OFS_CTRL |-> ##2 chan_a_mute_o == $past(writedata[0], 2);
  endproperty
  a_mute_a: assert property (p_mute_a) else $error("mute A wrong");
  property p_dac_pd;
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(ctrl.headphone_power_down) |=> dac_power_down_o == 2'h3;
  endproperty
  a_dac_pd: assert property (p_dac_pd) else $error("dac power wrong");
  property p_start;
    @(posedge clk_i) disable iff (sys_rst_i)
    start |=> state == hpld_pkg::ST_RES && !done && sense_en_o;
  endproperty
  a_start: assert property (p_start) else $error("start failed");
  // the code taken at the end of the wait; reserved 11 is shown as 10
  property p_res_code;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_res_end |=> res_stat == (($past(res_meas_i) == 2'h3) ? 2'h2
                                                           : $past(res_meas_i));
  endproperty
  a_res_code: assert property (p_res_code) else $error("bad code");
  // no tone leaks out from the second cycle after measuring has stopped
  property p_tone_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
    !sense_en_o && !$past(sense_en_o) |-> !test_tone_o;
  endproperty
  a_tone_idle: assert property (p_tone_idle) else $error("tone idle");
  property p_skip_cap;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_res_end ##0 res_meas_i < 2'h2 |=> done && !cap_stat && state == hpld_pkg::ST_DONE;
  endproperty
  a_skip_cap: assert property (p_skip_cap) else $error("cap not skipped");
  property p_cap_step;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_res_end ##0 res_meas_i[1] |=> state == hpld_pkg::ST_CAP && sense_en_o;
  endproperty
  a_cap_step: assert property (p_cap_step) else $error("cap step missed");
  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    state == hpld_pkg::ST_DONE && !start |=> $stable(res_stat) && $stable(cap_stat) && done;
  endproperty
  a_hold: assert property (p_hold) else $error("status moved");
  property p_rail;
    @(posedge clk_i) disable iff (sys_rst_i)
    ctrl.adaptive_rail_select == 3'h4 [*2] |-> rail_level_o == 2'h3;
  endproperty
  a_rail: assert property (p_rail) else $error("rail not fixed");
  property p_no_ramp;
    @(posedge clk_i) disable iff (sys_rst_i)
    !ramp_on |=> hp_vol_o == $past(vol_tgt[23:16]);
  endproperty
  a_no_ramp: assert property (p_no_ramp) else $error("volume late");
  property p_step;
    @(posedge clk_i) disable iff (sys_rst_i)
    ramp_on && $past(ramp_on) && hp_vol_o != $past(hp_vol_o) |->
      $past(fs_tick_i) && (hp_vol_o - $past(hp_vol_o) == 8'h1 ||
                           $past(hp_vol_o) - hp_vol_o == 8'h1);
  endproperty
  a_step: assert property (p_step) else $error("ramp jumped");
endmodule : hpld_ctrl

`default_nettype wire

/* verification/tb_top.sv */
// testbench: self-checking bench of the headphone load-detect block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %h want %h", $time, a, e); end end
module tb_top;
  logic        clk_i = 1'b0;     // 50 MHz clock
  logic        sys_rst_i = 1'b1; // reset, high
  logic [4:0]  address = 5'h00;  // bus address
  logic        read = 1'b0;      // bus read
  logic        write = 1'b0;     // bus write
  logic [31:0] writedata = '0;   // bus write data
  wire  [31:0] readdata;         // bus read data
  wire         waitrequest;      // bus stall
  logic        plug_event_i = 0; // plug pulse
  logic        headset_type_i = 0, cap_high_i = 0, fs_tick_i = 0;
  logic [1:0]  res_meas_i = 0, signal_rail_i = 0, ph = 0;
  wire         mute_a, mute_b, hp_pd, sense_en, sense_four;
  wire  [1:0]  dac_pd, rail, bias; // converter power, rail, bias
  wire         adc_pd, hpf, latch, max_l, load_c, tone; // path images
  wire  [7:0]  mix_v, dac_v, hp_v; // applied volumes
  logic [31:0] q, d, u, t;       // bus data and targets
  logic [23:0] pv;               // volumes seen one edge earlier
  logic [7:0]  m;                // last mixer volume
  logic        ramp_on = 0;      // step monitor armed
  int          failures = 0, checks_done = 0, i, n, k;
  hpld_ctrl #(.RES_CYC(4), .CAP_CYC(4)) u_hpld_ctrl (.clk_i, .sys_rst_i,
    .address, .read, .write, .writedata, .readdata, .waitrequest,
    .plug_event_i, .headset_type_i, .res_meas_i, .cap_high_i, .fs_tick_i,
    .signal_rail_i, .chan_a_mute_o(mute_a), .chan_b_mute_o(mute_b),
    .hp_power_down_o(hp_pd), .dac_power_down_o(dac_pd),
    .adc_power_down_o(adc_pd), .highpass_en_o(hpf),
    .latch_supply_o(latch), .bias_ctrl_o(bias), .max_level_o(max_l),
    .load_comp_o(load_c), .rail_level_o(rail), .test_tone_o(tone),
    .sense_four_o(sense_four), .sense_en_o(sense_en),
    .mix_vol_o(mix_v), .dac_vol_o(dac_v), .hp_vol_o(hp_v));
  always #10 clk_i = ~clk_i;
  // sample-rate tick every fourth cycle keeps ramp runs short
  always @(posedge clk_i)
  begin
    ph        <= ph + 2'h1;
    fs_tick_i <= (ph == 2'h3);
    pv        <= {hp_v, dac_v, mix_v};
    if (ramp_on) // no headphone or mixer jump larger than one setting while ramping
    begin
      `CHK(8'(hp_v - pv[23:16] + 8'h01) <= 8'h02, 1'b1)
      `CHK(8'(mix_v - pv[7:0] + 8'h01) <= 8'h02, 1'b1)
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // status a finished detection shows: {capacitance, resistance code}
  function automatic logic [2:0] exp_stat(input logic [1:0] r,
                                          input logic       c);
    exp_stat = (r[1] == 1'b0) ? {1'b0, r} : {c, 2'h2}; // 11 reads as 10
  endfunction : exp_stat
  // one access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int c;
    @(posedge clk_i);
    write <= w; read <= !w; address <= a; writedata <= wd;
    for (c = 0; c < 20; c++)
    begin
      @(posedge clk_i);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    if (c == 20) begin failures++; close_out(); end
    read <= 1'b0; write <= 1'b0;
  endtask : bus
  initial
  begin
    void'($urandom(32'h5bdc));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(0, hpld_pkg::OFS_CTRL, 0, q); `CHK(q, hpld_pkg::CTRL_RST)
    bus(0, hpld_pkg::OFS_RAMP, 0, q); `CHK(q, hpld_pkg::RAMP_RST)
    bus(0, 5'h14, 0, q); `CHK(q, 32'h0) // unmapped place reads zero
    for (i = 0; i < 8; i++) // all four silence bit codes, power bit random
    begin
      d = 32'(i % 4) | (32'($urandom % 2) << 2) | 32'h100;
      bus(1, hpld_pkg::OFS_CTRL, d, q); repeat (2) @(posedge clk_i); #1;
      `CHK({mute_b, mute_a}, d[1:0])
      `CHK({hp_pd, dac_pd}, {3{d[2]}})
    end
    for (i = 1; i < 6; i++) // fixed rail codes, then adapt-to-signal
    begin
      signal_rail_i <= 2'($urandom);
      bus(1, hpld_pkg::OFS_CTRL, 32'h3 | (32'(i == 5 ? 7 : i) << 8), q);
      repeat (2) @(posedge clk_i); #1;
      `CHK(rail, i == 5 ? signal_rail_i : 2'(i - 1))
    end
    for (i = 0; i < 4; i++) // every resistance code, reserved one too
    begin
      res_meas_i <= 2'(i); cap_high_i <= 1'($urandom);
      headset_type_i <= 1'($urandom);
      bus(1, hpld_pkg::OFS_RAMP, 32'h17, q);
      bus(1, hpld_pkg::OFS_CTRL, 32'h242F, q);
      plug_event_i <= 1'b1; @(posedge clk_i); plug_event_i <= 1'b0;
      bus(0, hpld_pkg::OFS_STATUS, 0, q); #1;
      `CHK(q[5:4], 2'b10)
      `CHK({sense_en, sense_four}, {1'b1, headset_type_i})
      for (n = 0; n < 40 && q[4] !== 1'b1; n++)
        bus(0, hpld_pkg::OFS_STATUS, 0, q);
      `CHK({q[5:4], tone}, 3'b010)
      `CHK(q[2:0], exp_stat(2'(i), cap_high_i))
    end
    // load compensation from the cap result, path down and muted
    d = 32'h083F | {19'h0, q[2], 12'h0} | {24'h0, 2'($urandom), 6'h0};
    bus(1, hpld_pkg::OFS_CTRL, d, q); repeat (2) @(posedge clk_i); #1;
    `CHK({load_c, max_l, bias}, {d[12:11], d[7:6]})
    `CHK({latch, hpf, adc_pd, hp_pd}, d[5:2])
    bus(1, hpld_pkg::OFS_CTRL, d & ~32'h4, q);
    repeat (2) @(posedge clk_i); #1;
    `CHK({hp_pd, dac_pd}, 3'h0)
    bus(1, hpld_pkg::OFS_CTRL, 32'h070F, q);
    plug_event_i <= 1'b1; @(posedge clk_i); plug_event_i <= 1'b0;
    bus(0, hpld_pkg::OFS_STATUS, 0, q); `CHK(q[5:4], 2'b01)
    t = $urandom;
    bus(1, hpld_pkg::OFS_RAMP, 0, q);
    bus(1, hpld_pkg::OFS_VOL, {8'h00, t[23:0]}, q); @(posedge clk_i); #1;
    `CHK({hp_v, dac_v, mix_v}, t[23:0])
    u = {8'h00, t[23:0] + 24'h101010};
    bus(1, hpld_pkg::OFS_RAMP, 32'h07F0, q); ramp_on = 1'b1;
    bus(1, hpld_pkg::OFS_VOL, u, q); repeat (2) @(posedge clk_i); #1;
    `CHK(hp_v === u[23:16], 1'b0)
    for (n = 0; n < 3000 && hp_v !== u[23:16]; n++) @(posedge clk_i);
    `CHK(hp_v, u[23:16])
    m = mix_v; // time one full mixer step at the slowest rate
    for (n = 0; n < 3000 && mix_v === m; n++) begin @(posedge clk_i); #1; end
    m = mix_v; k = 0;
    for (n = 0; n < 3000 && mix_v === m; n++)
    begin
      @(posedge clk_i); k += fs_tick_i; #1;
    end
    `CHK(k, 72)
    ramp_on = 1'b0;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
